// [smsm_consts.vh]
`ifndef SMSM_CONSTS_VH
`define SMSM_CONSTS_VH

// state codes, one-hot
`define SMSM_ST_INIT   5'b00001
`define SMSM_ST_OPER   5'b00010
`define SMSM_ST_WARN1  5'b00100
`define SMSM_ST_WARN2  5'b01000
`define SMSM_ST_FAULT  5'b10000

// fault cause bit positions in fault_cause input; flash count is position + 1
`define SMSM_F_OVERTEMP  0
`define SMSM_F_OVERVOLT  1
`define SMSM_F_SHORT     2
`define SMSM_F_POWER     3
`define SMSM_F_GROUND    4
`define SMSM_F_HWDEF     5
`define SMSM_F_OVERCUR   6

// times in seconds (flash time in milliseconds) and clock rate
`define SMSM_CLK_HZ      200000000
`define SMSM_T_SHORT_S   5
`define SMSM_T_LONG_S    15
`define SMSM_T_FLASH_MS  200

`endif

// [smsm_drive_model.sv]
`timescale 1ns/1ps
module smsm_drive_model (
  // clock and stop demands
  input  wire clk_sys,
  input  wire stop_soft,
  input  wire stop_quick,
  input  wire drive_off,
  // axis motion
  output reg  axis_on
);
  reg [3:0] coast = 4'h8;
  initial axis_on = 1'b0;
  // soft stop coasts a while, quick stop and off act at once
  always @(posedge clk_sys) begin
    if (stop_quick || drive_off) begin
      axis_on <= 1'b0;
      coast   <= 4'h8;
    end else if (stop_soft) begin
      coast   <= coast - {3'h0, coast != 4'h0};
      axis_on <= coast != 4'h0;
    end else begin
      axis_on <= 1'b1;
      coast   <= 4'h8;
    end
  end
endmodule // smsm_drive_model

// [smsm_props.sv]
`timescale 1ns/1ps
`include "smsm_consts.vh"
module smsm_props (
  // clock and conditions
  input wire       clk_sys,
  input wire       srst,
  input wire       clk_en,
  input wire       selftest_ok,
  input wire       mains_ok,
  input wire       warn1_cause,
  input wire [6:0] fault_cause,
  input wire [6:0] fault_delayed,
  // state and demands
  input wire [4:0] state,
  input wire       led_green,
  input wire       stop_quick,
  input wire       drive_off,
  input wire [2:0] fault_code
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_reset_init: assert property ($fell(srst) |-> state == `SMSM_ST_INIT)
    else $error("no init after reset");
  a_init_oper: assert property (clk_en && !fault_cause && state == 5'h01 && selftest_ok && mains_ok |=> state == 5'h02)
    else $error("init did not reach operation");
  a_oper_warn1: assert property (clk_en && !fault_cause && state == 5'h02 && mains_ok && warn1_cause |=> state == 5'h04)
    else $error("warning 1 not entered");
  a_oper_warn2: assert property (clk_en && !fault_cause && state == 5'h02 && !mains_ok |=> state == 5'h08)
    else $error("warning 2 not entered");
  a_oper_fault: assert property (clk_en && state == 5'h02 && (fault_cause & ~fault_delayed) |=> state == 5'h10)
    else $error("fault not entered");
  a_green_lit: assert property (clk_en && state == 5'h02 |=> led_green)
    else $error("green not lit in operation");
  a_quick_stop: assert property (clk_en && state == 5'h08 |=> stop_quick && !drive_off)
    else $error("no quick stop");
  a_fault_off: assert property (clk_en && state == 5'h10 |=> drive_off && !stop_quick)
    else $error("drives not switched off");
  a_latch_hold: assert property (clk_en && state == 5'h10 && fault_code == 3'h3 |=> state == 5'h10)
    else $error("latched fault released");
endmodule // smsm_props

bind smsm_supply_fsm smsm_props i_smsm_props (.*);

// [smsm_supply_fsm.v]
// Notes on behaviour
// - chopper usable 5 s after overload, then cooled
// - init runs self-test, green flashes
// - init to operation on self-test pass, power
// - init to fault, immediate or after 5 s
// - operation holds green lit
// - warning-1 cause enters warning 1, soft stop
// - warning-2 cause enters warning 2, quick stop
// - fault cause enters fault, drives off
// - warning 1 yellow single flash
// - warning 1 clears back to operation
// - phase loss in warning 1 to warning 2
// - fault cause in warning 1 to fault
// - warning 2 yellow double flash
// - power back within 5 s, charged: operation
// - power back after 5 s: initialization
// - no power 15 s or fault: fault
// - fault red flash pattern per cause
// - fault clears to init unless latched
// - defect, short, ground faults latch until restart
// - flash count one..seven identifies fault cause
`timescale 1ns/1ps
`include "smsm_consts.vh"

module smsm_supply_fsm #(
  parameter integer T_SHORT_CYC = `SMSM_T_SHORT_S * `SMSM_CLK_HZ,
  parameter [31:0]  T_LONG_CYC  = `SMSM_T_LONG_S * `SMSM_CLK_HZ,
  parameter integer FLASH_CYC   = (`SMSM_T_FLASH_MS * (`SMSM_CLK_HZ / 1000)),
  parameter integer CNT_W       = 32
) (
  // clock and control
  input  wire       clk_sys,
  input  wire       srst,
  input  wire       clk_en,
  // condition inputs
  input  wire       selftest_ok,
  input  wire       mains_ok,
  input  wire       dclink_charged,
  input  wire       warn1_cause,
  input  wire       phase_loss,
  input  wire [6:0] fault_cause,
  input  wire [6:0] fault_delayed,
  input  wire       brake_overload,
  input  wire       brake_hot,
  // state and indicators
  output reg  [4:0] state,
  output reg        led_green,
  output reg        led_yellow,
  output reg        led_red,
  // stop demands to drives
  output reg        stop_soft,
  output reg        stop_quick,
  output reg        drive_off,
  output reg        chopper_en,
  output reg  [2:0] fault_code
);

  localparam [4:0] ST_INIT  = `SMSM_ST_INIT;
  localparam [4:0] ST_OPER  = `SMSM_ST_OPER;
  localparam [4:0] ST_WARN1 = `SMSM_ST_WARN1;
  localparam [4:0] ST_WARN2 = `SMSM_ST_WARN2;
  localparam [4:0] ST_FAULT = `SMSM_ST_FAULT;
  // causes that must outlive their own removal until a restart
  localparam [6:0] LATCH_MASK = (7'h01 << `SMSM_F_SHORT) | (7'h01 << `SMSM_F_GROUND) |
                                (7'h01 << `SMSM_F_HWDEF);
  // limits cut to the counter width; CNT_W must hold T_LONG_CYC
  localparam [CNT_W-1:0] SHORT_LIM = T_SHORT_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] LONG_LIM  = T_LONG_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] FLASH_LIM = FLASH_CYC[CNT_W-1:0];

  // lowest set cause gives the flash count
  function [2:0] cause_code;
    input [6:0] c;
    integer i;
    begin
      cause_code = 3'h0;
      for (i = 6; i >= 0; i = i - 1) begin
        if (c[i]) begin
          cause_code = i[2:0] + 3'h1;
        end
      end
    end
  endfunction

  reg  [4:0]       next_state;

  // fault bookkeeping
  wire [6:0]       dly_done;
  reg  [6:0]       latched;
  reg              pwr_fail;
  wire [6:0]       pwr_vec;

  // warning-2 timer and brake chopper
  reg  [CNT_W-1:0] w2_cnt;
  reg  [CNT_W-1:0] brk_cnt;
  reg              brk_cool_wait;

  // indicator timebase
  reg  [CNT_W-1:0] flash_cnt;
  reg              tick;
  reg  [3:0]       slot;
  reg  [2:0]       code_hold;
  wire [6:0]       fault_now;
  wire             fault_any;
  wire             w2_short;
  wire             w2_long;
  wire [2:0]       next_code;
  reg              blink;
  reg  [2:0]       burst_n;

  // delayed causes count up while present, immediate ones act at once
  // each cause keeps its own timer, so two delayed causes never share a start
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : g_dly
      reg [CNT_W-1:0] cnt;
      reg             done;
      always @(posedge clk_sys) begin
        if (srst) begin
          cnt  <= {CNT_W{1'b0}};
          done <= 1'b0;
        end else if (clk_en) begin
          if (!fault_cause[g] || !fault_delayed[g]) begin
            cnt  <= {CNT_W{1'b0}};
            done <= 1'b0;
          end else if (cnt >= SHORT_LIM - 1'b1) begin
            done <= 1'b1;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
      end
      assign dly_done[g] = done;
    end
  endgenerate

  // a warning-2 timeout stands for the power-failure cause until mains return
  assign pwr_vec   = {6'h00, pwr_fail} << `SMSM_F_POWER;
  assign fault_now = (fault_cause & ~fault_delayed) | dly_done | latched | pwr_vec;
  assign fault_any = |fault_now;
  // the warning-2 timer starts on the first cycle spent in warning 2
  assign w2_short  = (w2_cnt < SHORT_LIM);
  assign w2_long   = (w2_cnt >= LONG_LIM - 1'b1);
  assign next_code = cause_code(fault_now);

  // priority fault, warning 2, warning 1
  always @* begin
    next_state = state;
    case (state)
      ST_INIT: begin
        if (fault_any) begin
          next_state = ST_FAULT;
        end else if (selftest_ok && mains_ok) begin
          next_state = ST_OPER;
        end
      end
      ST_OPER: begin
        if (fault_any) begin
          next_state = ST_FAULT;
        end else if (!mains_ok) begin
          next_state = ST_WARN2;
        end else if (warn1_cause || phase_loss) begin
          next_state = ST_WARN1;
        end
      end
      ST_WARN1: begin
        if (fault_any) begin
          next_state = ST_FAULT;
        end else if (phase_loss || !mains_ok) begin
          next_state = ST_WARN2;
        end else if (!warn1_cause) begin
          next_state = ST_OPER;
        end
      end
      ST_WARN2: begin
        if (fault_any || (!mains_ok && w2_long)) begin
          next_state = ST_FAULT;
        // a phase loss alone keeps warning 2 even with mains back
        end else if (mains_ok && !phase_loss) begin
          if (w2_short && dclink_charged) begin
            next_state = ST_OPER;
          end else begin
            next_state = ST_INIT;
          end
        end
      end
      ST_FAULT: begin
        // latched causes stay in fault_now, so once one is latched only srst leaves here
        // cause removed
        if (!fault_any) begin
          next_state = ST_INIT;
        end
      end
      default: begin
        next_state = ST_INIT;
      end
    endcase
  end

  // reset enters init, counters time warning 2
  always @(posedge clk_sys) begin
    if (srst) begin
      state     <= ST_INIT;
      w2_cnt    <= {CNT_W{1'b0}};
      latched   <= 7'h00;
      code_hold <= 3'h0;
    end else if (clk_en) begin
      state <= next_state;
      if (next_state != ST_WARN2 || state != ST_WARN2) begin
        w2_cnt <= {CNT_W{1'b0}};
      end else if (!w2_long) begin
        w2_cnt <= w2_cnt + 1'b1;
      end
      latched <= latched | (fault_cause & LATCH_MASK);
      if (next_state == ST_FAULT) begin
        code_hold <= next_code;
      end
    end
  end

  // lasting power failure
  // raised on the 15 s timeout, held while mains stay away
  always @(posedge clk_sys) begin
    if (srst) begin
      pwr_fail <= 1'b0;
    end else if (clk_en) begin
      if (mains_ok) begin
        pwr_fail <= 1'b0;
      end else if (state == ST_WARN2 && w2_long) begin
        pwr_fail <= 1'b1;
      end
    end
  end

  // 5 s grace then wait for cooling
  // chopper stays usable through the grace time; cooling matters only after it
  always @(posedge clk_sys) begin
    if (srst) begin
      brk_cnt       <= {CNT_W{1'b0}};
      brk_cool_wait <= 1'b0;
      chopper_en    <= 1'b1;
    end else if (clk_en) begin
      if (brk_cool_wait) begin
        chopper_en <= 1'b0;
        if (!brake_hot) begin
          brk_cool_wait <= 1'b0;
          brk_cnt       <= {CNT_W{1'b0}};
          chopper_en    <= 1'b1;
        end
      end else if (brake_overload) begin
        chopper_en <= 1'b1;
        if (brk_cnt >= SHORT_LIM - 1'b1) begin
          brk_cool_wait <= 1'b1;
          chopper_en    <= 1'b0;
        end else begin
          brk_cnt <= brk_cnt + 1'b1;
        end
      end else begin
        brk_cnt    <= {CNT_W{1'b0}};
        chopper_en <= 1'b1;
      end
    end
  end

  // flash timebase: 16 slots per burst, flashes on even slots, rest is pause
  // one free-running timebase keeps all three indicators in step
  always @(posedge clk_sys) begin
    if (srst) begin
      flash_cnt <= {CNT_W{1'b0}};
      tick      <= 1'b0;
      slot      <= 4'h0;
    end else if (clk_en) begin
      tick <= 1'b0;
      if (flash_cnt >= FLASH_LIM - 1'b1) begin
        flash_cnt <= {CNT_W{1'b0}};
        tick      <= 1'b1;
        slot      <= slot + 4'h1;
      end else begin
        flash_cnt <= flash_cnt + 1'b1;
      end
    end
  end

  always @* begin
    case (state)
      ST_WARN1: burst_n = 3'h1;
      ST_WARN2: burst_n = 3'h2;
      ST_FAULT: burst_n = code_hold;
      default:  burst_n = 3'h0;
    endcase
    blink = !slot[0] && (slot[3:1] < burst_n);
  end

  // outputs all registered
  always @(posedge clk_sys) begin
    if (srst) begin
      led_green  <= 1'b0;
      led_yellow <= 1'b0;
      led_red    <= 1'b0;
      stop_soft  <= 1'b0;
      stop_quick <= 1'b0;
      drive_off  <= 1'b1;
      fault_code <= 3'h0;
    end else if (clk_en) begin
      // derived from registered state, so every output lags state by one clock

      led_green  <= (state == ST_INIT) ? slot[0] : (state != ST_FAULT);

      led_yellow <= (state == ST_WARN1 || state == ST_WARN2) && blink;

      led_red    <= (state == ST_FAULT) && blink;

      stop_soft  <= (state == ST_WARN1);

      stop_quick <= (state == ST_WARN2);

      // drives switched off
      // drives stay off through init so a restart never meets a live axis
      drive_off  <= (state == ST_FAULT) || (state == ST_INIT);

      fault_code <= (state == ST_FAULT) ? code_hold : 3'h0;
    end
  end

endmodule // smsm_supply_fsm

// [smsm_supply_fsm_tb_top.sv]
`timescale 1ns/1ps
`include "smsm_consts.vh"
module smsm_supply_fsm_tb_top;
  reg         clk_sys, srst, clk_en, selftest_ok, mains_ok, dclink_charged;
  reg         warn1_cause, phase_loss, brake_overload, brake_hot;
  reg  [6:0]  fault_cause, fault_delayed;
  reg  [17:0] rows [0:10];
  reg  [4:0]  n_flash;
  wire [4:0]  state;
  wire [2:0]  fault_code;
  wire        led_green, led_yellow, led_red, stop_soft, stop_quick, drive_off, chopper_en, axis_on;
  integer     fail_count = 0;
  integer     total_checks = 0;
  integer     i;

  smsm_supply_fsm #(.T_SHORT_CYC(50), .T_LONG_CYC(150), .FLASH_CYC(4)) i_smsm_supply_fsm (.*);
  smsm_drive_model i_smsm_drive_model (.*);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task cyc(input integer n);
    repeat (n) @(negedge clk_sys);
  endtask

  task chk(input string nm, input [4:0] seen, input [4:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // rises of one indicator over one 16-slot burst of 4 cycles each
  task count_flash(input sel, output [4:0] n);
    reg prev;
    reg cur;
    begin
      n = 5'h00;
      prev = sel ? led_red : led_yellow;
      repeat (64) begin
        @(negedge clk_sys);
        cur = sel ? led_red : led_yellow;
        if (cur && !prev) n = n + 5'h01;
        prev = cur;
      end
    end
  endtask

  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  task to_oper(input integer n);
    begin
      srst = 1'b1;
      {clk_en, selftest_ok, mains_ok, dclink_charged} = 4'hf;
      {warn1_cause, phase_loss, brake_overload, brake_hot} = 4'h0;
      fault_cause = 7'h00;
      fault_delayed = 7'h00;
      cyc(n);
      chk("reset", {state[3:0], drive_off & chopper_en}, 5'h03);
      srst = 1'b0;
      cyc(3);
      chk("state", state, `SMSM_ST_OPER);
    end
  endtask

  initial begin
    to_oper(12);
    rows[0] = {3'b110, 7'h00, `SMSM_ST_WARN1, 3'h0};
    rows[1] = {3'b000, 7'h00, `SMSM_ST_WARN2, 3'h0};
    rows[2] = {3'b011, 7'h00, `SMSM_ST_WARN2, 3'h0};
    rows[3] = {3'b100, 7'h00, `SMSM_ST_WARN2, 3'h0};
    for (i = 0; i < 7; i = i + 1)
      rows[4 + i] = {3'b100, 7'h01 << i, `SMSM_ST_FAULT, 3'(i + 1)};
    for (i = 0; i < 11; i = i + 1) begin
      to_oper(2);
      {warn1_cause, mains_ok, phase_loss, fault_cause} = rows[i][17:8];
      cyc(4);
      chk("state", state, rows[i][7:3]);
      chk("code", {2'h0, fault_code}, {2'h0, rows[i][2:0]});
    end
    to_oper(2);
    mains_ok = 1'b0;
    cyc(20);
    mains_ok = 1'b1;
    cyc(3);
    chk("quick return", state, `SMSM_ST_OPER);
    mains_ok = 1'b0;
    selftest_ok = 1'b0;
    cyc(70);
    mains_ok = 1'b1;
    cyc(3);
    chk("late return", state, `SMSM_ST_INIT);
    to_oper(2);
    mains_ok = 1'b0;
    cyc(170);
    chk("no return", {state[4:3], fault_code}, 5'h14);
    to_oper(2);
    warn1_cause = 1'b1;
    cyc(3);
    warn1_cause = 1'b0;
    cyc(3);
    chk("warn1 clear", state, `SMSM_ST_OPER);
    warn1_cause = 1'b1;
    cyc(3);
    fault_cause = 7'h01;
    cyc(3);
    chk("warn1 fault", state, `SMSM_ST_FAULT);
    fault_cause = 7'h00;
    selftest_ok = 1'b0;
    cyc(4);
    chk("fault clear", state, `SMSM_ST_INIT);
    // only short, ground and defect hold on
    for (i = 2; i < 6; i = i + 1) begin
      if (i != 3) begin
        to_oper(2);
        fault_cause = 7'h01 << i;
        cyc(3);
        fault_cause = 7'h00;
        cyc(10);
        chk("latched", state, `SMSM_ST_FAULT);
      end
    end
    srst = 1'b1;
    selftest_ok = 1'b0;
    cyc(2);
    srst = 1'b0;
    fault_cause = 7'h02;
    fault_delayed = 7'h02;
    cyc(30);
    chk("delayed early", state, `SMSM_ST_INIT);
    cyc(40);
    chk("delayed late", state, `SMSM_ST_FAULT);
    to_oper(2);
    {brake_overload, brake_hot} = 2'b11;
    cyc(30);
    chk("chopper grace", {4'h0, chopper_en}, 5'h01);
    cyc(40);
    chk("chopper off", {4'h0, chopper_en}, 5'h00);
    {brake_overload, brake_hot} = 2'b00;
    cyc(3);
    chk("chopper back", {4'h0, chopper_en}, 5'h01);
    to_oper(2);
    chk("axis run", {4'h0, axis_on}, 5'h01);
    warn1_cause = 1'b1;
    cyc(3);
    count_flash(1'b0, n_flash);
    chk("yellow 1x", n_flash, 5'h01);
    chk("soft stop", {3'h0, stop_soft, axis_on}, 5'h02);
    mains_ok = 1'b0;
    cyc(3);
    count_flash(1'b0, n_flash);
    chk("yellow 2x", n_flash, 5'h02);
    fault_cause = 7'h40;
    cyc(3);
    count_flash(1'b1, n_flash);
    chk("red 7x", n_flash, 5'h07);
    wrap_up;
  end

  // about twelve times the expected run
  initial begin
    #50000;
    fail_count = fail_count + 1;
    wrap_up;
  end
endmodule // smsm_supply_fsm_tb_top
